// file: src/fault_pkg.sv
// Shared constants, types and register map for the servo fault manager.
package fault_pkg;

	// Fault sources: bit i of a source vector carries fault code i + FIRST_CODE.
	localparam int NUM_SRC    = 19;
	localparam int FIRST_CODE = 2;
	localparam int CODE_W     = 5;

	typedef logic [CODE_W-1:0]              code_t;
	typedef logic [NUM_SRC-1:0]             src_t;
	typedef logic [NUM_SRC-1:0][CODE_W-1:0] order_t;

	localparam code_t CODE_NONE = 5'h01;

	localparam int SRC_DRIVE_IT = 2;
	localparam int SRC_BUS_OV   = 5;
	localparam int SRC_BUS_UV   = 6;

	// Bus over- and undervoltage reset themselves; every other source is latched.
	localparam src_t LATCH_CLASS_RESET = 19'h7FF9F;

	// Default priority: a lower fault code wins.
	function automatic order_t default_order();
		order_t o;
		for (int i = 0; i < NUM_SRC; i++) begin
			o[i] = code_t'(i + FIRST_CODE);
		end
		return o;
	endfunction : default_order

	localparam order_t PRIO_ORDER_DEFAULT = default_order();

	// Register map, byte addresses on an 8-bit APB address.
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_RAW      = 8'h08;
	localparam logic [7:0] ADDR_LATCHED  = 8'h0C;
	localparam logic [7:0] ADDR_CLASS    = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	localparam int         CTRL_SW_EN_BIT = 0;
	localparam int         CTRL_FOLD_BIT  = 1;
	localparam logic [1:0] CTRL_RESET     = 2'h1;

	localparam int STAT_CODE_LSB  = 0;
	localparam int STAT_STAGE_BIT = 8;
	localparam int STAT_FOLD_BIT  = 9;
	localparam int STAT_RECOV_BIT = 10;
	localparam int STAT_LED_BIT   = 11;
	localparam int STAT_MODE_LSB  = 12;

	localparam int         IRQ_W         = 3;
	localparam int         IRQ_FAULT_BIT = 0;
	localparam int         IRQ_READY_BIT = 1;
	localparam int         IRQ_FOLD_BIT  = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	localparam logic [6:0] PEAK_FULL_PCT = 7'h64;
	localparam logic [6:0] PEAK_FOLD_PCT = 7'h43;

	// Timing at a 100 MHz clock.
	localparam int CLK_HZ          = 100_000_000;
	localparam int RECOVER_MS      = 50;
	localparam int RECOVER_CYCLES  = RECOVER_MS * (CLK_HZ / 1000);
	localparam int FAST_HALF_MS    = 50;
	localparam int FAST_HALF_CYCLES = FAST_HALF_MS * (CLK_HZ / 1000);
	localparam int SLOW_HALF_MS    = 250;
	localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * (CLK_HZ / 1000);
	localparam int PAUSE_MS        = 1000;
	localparam int PAUSE_CYCLES    = PAUSE_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {MODE_STEADY, MODE_FAST, MODE_CODE} led_mode_t;

endpackage : fault_pkg

// file: src/led_cmd_if.sv
// Command and drive signals between the fault logic and the LED sequencer.
`timescale 1ns/100ps
interface led_cmd_if;
	fault_pkg::led_mode_t mode;
	fault_pkg::code_t     code;
	logic                 led;

	modport src (output mode, output code, input led);
	modport dst (input mode, input code, output led);
endinterface : led_cmd_if

// file: src/led_sequencer.sv
// Status LED pattern generator: steady, fast blink, or counted bursts with a pause.
`timescale 1ns/100ps
module led_sequencer #(
	parameter int FAST_HALF  = fault_pkg::FAST_HALF_CYCLES,
	parameter int SLOW_HALF  = fault_pkg::SLOW_HALF_CYCLES,
	parameter int PAUSE_LEN  = fault_pkg::PAUSE_CYCLES
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Command from the fault logic
	led_cmd_if.dst    cmd
);

	typedef enum logic [2:0] {ST_STEADY, ST_FAST, ST_PULSE_ON, ST_PULSE_OFF, ST_PAUSE} seq_t;

	seq_t                  state;
	seq_t                  next_state;
	logic [31:0]           cnt;
	logic [31:0]           next_cnt;
	fault_pkg::code_t      left;
	fault_pkg::code_t      next_left;
	logic                  led;
	logic                  next_led;
	logic                  in_burst;
	logic                  expired;

	assign expired  = (cnt == 32'h0);
	assign in_burst = (state == ST_PULSE_ON) || (state == ST_PULSE_OFF) || (state == ST_PAUSE);
	assign cmd.led  = led;

	always_comb begin
		next_state = state;
		next_cnt   = expired ? 32'h0 : cnt - 32'h1;
		next_left  = left;
		next_led   = led;
		case (cmd.mode)
			fault_pkg::MODE_STEADY: begin
				next_state = ST_STEADY; // R1
				next_led   = 1'b1;
				next_cnt   = 32'h0;
			end
			fault_pkg::MODE_FAST: begin
				next_state = ST_FAST; // R2
				if (state != ST_FAST || expired) begin
					next_cnt = 32'(FAST_HALF - 1); // R15
					next_led = (state == ST_FAST) ? ~led : 1'b1;
				end
			end
			default: begin
				if (!in_burst) begin
					next_state = ST_PULSE_ON; // R3
					next_left  = cmd.code;
					next_cnt   = 32'(SLOW_HALF - 1);
					next_led   = 1'b1;
				end else if (expired) begin
					case (state)
						ST_PULSE_ON: begin
							next_state = ST_PULSE_OFF;
							next_left  = left - 5'h01;
							next_cnt   = 32'(SLOW_HALF - 1);
							next_led   = 1'b0;
						end
						ST_PULSE_OFF: begin
							if (left == 5'h00) begin
								next_state = ST_PAUSE; // R3
								next_cnt   = 32'(PAUSE_LEN - 1);
							end else begin
								next_state = ST_PULSE_ON;
								next_cnt   = 32'(SLOW_HALF - 1);
								next_led   = 1'b1;
							end
						end
						default: begin
							next_state = ST_PULSE_ON;
							next_left  = cmd.code;
							next_cnt   = 32'(SLOW_HALF - 1);
							next_led   = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_FAST;
			cnt   <= 32'h0;
			left  <= 5'h00;
			led   <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			left  <= next_left;
			led   <= next_led;
		end
	end

endmodule : led_sequencer

// file: src/servo_fault_manager_led.sv
// Fault supervision for a servo drive output stage with status LED and APB registers.
//
// Notes on behaviour
// R1 - LED steadily lit while output stage enabled and no fault active.
// R2 - LED blinks fast when no fault but output stage disabled.
// R3 - Faults shown as slow blink bursts with pause; blink count equals code.
// R4 - Codes 1 to 8: none, temperatures, current-time, battery, bus voltages.
// R5 - Codes 9 to 20: shorts, overcurrent, Hall, feedback unit, option card, position.
// R6 - Only latched-class fault sources are captured and held.
// R7 - Any fault disables the output stage and its code is displayed.
// R8 - Non-latched faults re-enable the stage automatically after they clear.
// R9 - Latched faults clear only by enable input disable or power cycle.
// R10 - Self-resetting faults keep the stage off 50 to 100 ms after clearing.
// R11 - With several faults active only the highest priority one is shown.
// R12 - After clearing and enable cycling the next remaining fault is shown.
// R13 - Drive current-time excess either folds peak limit to 67% or faults.
// R14 - Priority order is a parameter; lower code wins by default.
// R15 - Blink periods and pause length are parameters in clock cycles.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
module servo_fault_manager_led #(
	parameter fault_pkg::order_t PRIO_ORDER  = fault_pkg::PRIO_ORDER_DEFAULT,
	parameter int               RECOVER_LEN = fault_pkg::RECOVER_CYCLES,
	parameter int               FAST_HALF   = fault_pkg::FAST_HALF_CYCLES,
	parameter int               SLOW_HALF   = fault_pkg::SLOW_HALF_CYCLES,
	parameter int               PAUSE_LEN   = fault_pkg::PAUSE_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Protection detectors and hardware enable
	input  wire logic [18:0] fault_detect,
	input  wire logic        enable_n,
	// Output stage control
	output logic             stage_enable,
	output logic             foldback_active,
	output logic      [6:0]  peak_limit_pct,
	// Front panel and interrupt
	output logic             status_led,
	output logic             irq
);

	// Picks the highest priority active source as a fault code.
	function automatic fault_pkg::code_t pick_code(input fault_pkg::src_t act);
		fault_pkg::code_t c;
		int               idx;
		c = fault_pkg::CODE_NONE;
		for (int i = fault_pkg::NUM_SRC - 1; i >= 0; i--) begin
			idx = int'(PRIO_ORDER[i]) - fault_pkg::FIRST_CODE;
			if (idx >= 0 && idx < fault_pkg::NUM_SRC && act[idx]) begin
				c = PRIO_ORDER[i]; // R11
			end
		end
		return c;
	endfunction : pick_code

	// Register state.
	logic [1:0]                    ctrl;
	fault_pkg::src_t               latch_class;
	logic [fault_pkg::IRQ_W-1:0]   irq_status;
	logic [fault_pkg::IRQ_W-1:0]   irq_mask;

	// Fault state.
	fault_pkg::src_t               latched;
	fault_pkg::code_t              report_code;
	logic [31:0]                   recover_cnt;
	logic                          fault_any_q;
	logic                          stage_q;
	logic                          fold_q;

	// Decode and status wires.
	logic                          sw_enable;
	logic                          fold_enable;
	fault_pkg::src_t               fold_mask;
	fault_pkg::src_t               raw;
	fault_pkg::src_t               next_latched;
	fault_pkg::src_t               active;
	fault_pkg::src_t               self_active;
	logic                          fault_any;
	logic                          self_any;
	logic                          recovering;
	logic                          next_stage;
	logic                          next_fold;
	logic [31:0]                   next_recover;
	logic [fault_pkg::IRQ_W-1:0]   events;
	logic [fault_pkg::IRQ_W-1:0]   next_irq_status;

	// Terms shared by the stage, interrupt and LED paths.
	fault_pkg::src_t               new_latch;
	logic [fault_pkg::IRQ_W-1:0]   irq_clear;
	logic                          show_code;

	// Bus decode wires.
	logic                          bus_access;
	logic                          setup;
	logic                          rd_setup;
	logic                          wr_access;
	logic                          hit_ctrl;
	logic                          hit_status;
	logic                          hit_raw;
	logic                          hit_latched;
	logic                          hit_class;
	logic                          hit_irq_stat;
	logic                          hit_irq_mask;
	logic                          mapped;
	logic [31:0]                   status_word;
	logic [31:0]                   rd_data;

	led_cmd_if led_bus ();

	led_sequencer #(
		.FAST_HALF (FAST_HALF),
		.SLOW_HALF (SLOW_HALF),
		.PAUSE_LEN (PAUSE_LEN)
	) u_led (
		.pclk    (pclk),
		.presetn (presetn),
		.cmd     (led_bus.dst)
	);

	assign sw_enable   = ctrl[fault_pkg::CTRL_SW_EN_BIT];
	assign fold_enable = ctrl[fault_pkg::CTRL_FOLD_BIT];
	assign raw         = fault_fix(fault_detect);

	// Identity on the source vector; keeps the port width tied to the source type.
	function automatic fault_pkg::src_t fault_fix(input logic [18:0] v);
		return fault_pkg::src_t'(v);
	endfunction : fault_fix

	// With foldback selected, the drive current-time source limits current instead.
	assign fold_mask = fold_enable ? ~(fault_pkg::src_t'(1) << fault_pkg::SRC_DRIVE_IT)
	                               : {fault_pkg::NUM_SRC{1'b1}}; // R13
	assign next_fold = fold_enable & raw[fault_pkg::SRC_DRIVE_IT]; // R13

	// Latched sources are captured; a fresh detection wins over the enable clear.
	assign new_latch    = raw & latch_class & fold_mask; // R6
	assign next_latched = (latched & {fault_pkg::NUM_SRC{~enable_n}}) | new_latch; // R6 R9

	// Non-latched sources count only while present.
	assign self_active = raw & ~latch_class & fold_mask; // R6 R8
	assign active      = latched | self_active;
	assign fault_any   = |active;
	assign self_any    = |self_active;

	// Recovery timer reloads while a self-resetting fault is present.
	// Reloading while the source stands makes the hold time count from the clear.
	assign next_recover = self_any ? 32'(RECOVER_LEN)
	                    : (recover_cnt == 32'h0) ? 32'h0 : recover_cnt - 32'h1; // R10
	assign recovering   = (recover_cnt != 32'h0);

	// A latched source that is only now being captured already blocks the stage, so
	// the stage goes off on the first edge after the fault reaches its inputs.
	assign next_stage = ~enable_n & sw_enable & ~fault_any & ~(|new_latch)
	                  & ~recovering & ~self_any; // R7 R8 R10

	assign events[fault_pkg::IRQ_FAULT_BIT] = fault_any & ~fault_any_q;
	assign events[fault_pkg::IRQ_READY_BIT] = next_stage & ~stage_q;
	assign events[fault_pkg::IRQ_FOLD_BIT]  = next_fold & ~fold_q;

	// Write-one-to-clear; a new event in the same cycle keeps its bit set.
	assign irq_clear       = (wr_access & hit_irq_stat) ? pwdata[fault_pkg::IRQ_W-1:0]
	                                                    : {fault_pkg::IRQ_W{1'b0}};
	assign next_irq_status = (irq_status & ~irq_clear) | events;

	// LED command: a fault code wins, then steady when running, else fast blink.
	assign show_code    = (report_code != fault_pkg::CODE_NONE);
	assign led_bus.mode = show_code ? fault_pkg::MODE_CODE
	                    : stage_q ? fault_pkg::MODE_STEADY
	                    : fault_pkg::MODE_FAST; // R1 R2 R3 R7
	assign led_bus.code = report_code; // R4 R5

	assign status_led      = led_bus.led;
	assign stage_enable    = stage_q;
	assign foldback_active = fold_q;
	assign irq             = |(irq_status & irq_mask);

	// APB decode; no wait states.
	assign bus_access   = psel & penable;
	assign setup        = psel & ~penable;
	assign rd_setup     = setup & ~pwrite;
	assign wr_access    = bus_access & pwrite;
	assign hit_ctrl     = (paddr == fault_pkg::ADDR_CTRL);
	assign hit_status   = (paddr == fault_pkg::ADDR_STATUS);
	assign hit_raw      = (paddr == fault_pkg::ADDR_RAW);
	assign hit_latched  = (paddr == fault_pkg::ADDR_LATCHED);
	assign hit_class    = (paddr == fault_pkg::ADDR_CLASS);
	assign hit_irq_stat = (paddr == fault_pkg::ADDR_IRQ_STAT);
	assign hit_irq_mask = (paddr == fault_pkg::ADDR_IRQ_MASK);
	assign mapped       = hit_ctrl | hit_status | hit_raw | hit_latched
	                    | hit_class | hit_irq_stat | hit_irq_mask;
	assign pready       = 1'b1;
	assign pslverr      = bus_access & ~mapped;

	always_comb begin
		status_word = 32'h0;
		status_word[fault_pkg::STAT_CODE_LSB +: fault_pkg::CODE_W] = report_code;
		status_word[fault_pkg::STAT_STAGE_BIT] = stage_q;
		status_word[fault_pkg::STAT_FOLD_BIT]  = fold_q;
		status_word[fault_pkg::STAT_RECOV_BIT] = recovering;
		status_word[fault_pkg::STAT_LED_BIT]   = led_bus.led;
		status_word[fault_pkg::STAT_MODE_LSB +: 2] = led_bus.mode;
	end

	assign rd_data = hit_ctrl     ? {30'h0, ctrl}
	               : hit_status   ? status_word
	               : hit_raw      ? {13'h0, raw}
	               : hit_latched  ? {13'h0, latched}
	               : hit_class    ? {13'h0, latch_class}
	               : hit_irq_stat ? {29'h0, irq_status}
	               : hit_irq_mask ? {29'h0, irq_mask}
	               : 32'h0;

	// Read data is captured in the setup cycle and stands through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= rd_data;
		end
	end

	// Writes touch only the implemented bits of each register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= fault_pkg::CTRL_RESET;
		end else if (wr_access && hit_ctrl) begin
			ctrl <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_class <= fault_pkg::LATCH_CLASS_RESET;
		end else if (wr_access && hit_class) begin
			latch_class <= pwdata[fault_pkg::NUM_SRC-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= fault_pkg::IRQ_MASK_RESET;
		end else if (wr_access && hit_irq_mask) begin
			irq_mask <= pwdata[fault_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {fault_pkg::IRQ_W{1'b0}};
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Power-on reset stands for a control power cycle and clears every latched fault.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched <= {fault_pkg::NUM_SRC{1'b0}}; // R9
		end else begin
			latched <= next_latched; // R6 R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// The shown code tracks the live set, so the next remaining fault follows a clear.
			report_code <= fault_pkg::CODE_NONE;
		end else begin
			report_code <= pick_code(active); // R11 R12 R14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recover_cnt <= 32'h0;
		end else begin
			recover_cnt <= next_recover; // R10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q <= 1'b0;
		end else begin
			stage_q <= next_stage; // R7
		end
	end

	// Previous fault state, for the onset event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_any_q <= 1'b0;
		end else begin
			fault_any_q <= fault_any;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fold_q <= 1'b0;
		end else begin
			fold_q <= next_fold; // R13
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peak_limit_pct <= fault_pkg::PEAK_FULL_PCT;
		end else begin
			peak_limit_pct <= next_fold ? fault_pkg::PEAK_FOLD_PCT
			                            : fault_pkg::PEAK_FULL_PCT; // R13
		end
	end

endmodule : servo_fault_manager_led

// file: dv/servo_fault_checker.sv
// Concurrent checks on the ports of the servo fault manager.
`timescale 1ns/100ps
module servo_fault_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic [18:0] fault_detect,
	input wire logic        enable_n,
	input wire logic        stage_enable,
	input wire logic        foldback_active,
	input wire logic [6:0]  peak_limit_pct,
	input wire logic        status_led
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	stage_hw_off_a: assert property (enable_n |=> !stage_enable)
		else $error("stage enabled while hardware enable was off");
	fault_stage_off_a: assert property (
		(|fault_detect[18:3] || |fault_detect[1:0]) |=> !stage_enable)
		else $error("stage stayed enabled during a fault");
	peak_fold_a: assert property (
		peak_limit_pct == (foldback_active ? 7'h43 : 7'h64))
		else $error("peak limit does not follow foldback");
	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("bus access not answered at once");
	unmapped_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access without error");
	led_steady_a: assert property (stage_enable [*8] |-> status_led)
		else $error("led dark while stage enabled");
	recover_hold_a: assert property (
		$fell(fault_detect[fault_pkg::SRC_BUS_OV]) |-> (!stage_enable) [*8])
		else $error("stage back too soon after bus fault");
	latch_hold_a: assert property (
		$fell(fault_detect[0]) && !enable_n |=> (!stage_enable) [*4])
		else $error("held fault released without enable cycle");
endmodule : servo_fault_checker

bind servo_fault_manager_led servo_fault_checker u_servo_fault_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .fault_detect(fault_detect),
	.enable_n(enable_n), .stage_enable(stage_enable), .foldback_active(foldback_active),
	.peak_limit_pct(peak_limit_pct), .status_led(status_led));

// file: dv/fault_partner.sv
// Detector and enable source model with an observer of the status LED.
`timescale 1ns/100ps
module fault_partner #(
	parameter int GAP = 14
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Scenario control
	input  wire logic [18:0] fault_req,
	input  wire logic        disable_req,
	// Toward the block
	output logic      [18:0] fault_detect,
	output logic             enable_n,
	input  wire logic        status_led,
	// Observations
	output int               run_len,
	output int               burst_cnt,
	output logic             burst_done
);
	int   cnt;
	int   pulses;
	logic prev;

	assign fault_detect = fault_req;
	// Raising the enable line is how held faults get cleared.
	assign enable_n = disable_req;

	// A dark phase longer than any slow off time ends a burst.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
			cnt <= 0;
			pulses <= 0;
			run_len <= 0;
			burst_cnt <= 0;
			burst_done <= 1'b0;
		end else begin
			prev <= status_led;
			burst_done <= 1'b0;
			if (status_led != prev) begin
				run_len <= cnt;
				cnt <= 1;
			end else begin
				cnt <= cnt + 1;
			end
			if (status_led && !prev) begin
				pulses <= pulses + 1;
			end
			if (!status_led && cnt == GAP && pulses != 0) begin
				burst_done <= 1'b1;
				burst_cnt <= pulses;
				pulses <= 0;
			end
		end
	end
endmodule : fault_partner

// file: dv/tb_top.sv
// Self-checking bench for the servo fault manager.
`timescale 1ns/100ps
module tb_top;
	localparam int RECOVER = 20;
	localparam int FAST    = 4;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [18:0] fault_detect;
	logic [18:0] fault_req;
	logic        enable_n;
	logic        disable_req;
	logic        stage_enable;
	logic        foldback_active;
	logic [6:0]  peak_limit_pct;
	logic        status_led;
	logic        irq;
	int          run_len;
	int          burst_cnt;
	logic        burst_done;
	int          num_errors;
	int          cmp_count;
	int          seed;
	int          n;
	logic [31:0] v;
	logic [63:0] e;
	logic [63:0] rd_q[$];
	int          blink_q[$];

	servo_fault_manager_led #(.RECOVER_LEN(RECOVER), .FAST_HALF(FAST), .SLOW_HALF(6),
		.PAUSE_LEN(20)) u_servo_fault_manager_led (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_detect(fault_detect), .enable_n(enable_n),
		.stage_enable(stage_enable), .foldback_active(foldback_active),
		.peak_limit_pct(peak_limit_pct), .status_led(status_led), .irq(irq));

	fault_partner u_fault_partner (
		.pclk(pclk), .presetn(presetn), .fault_req(fault_req), .disable_req(disable_req),
		.fault_detect(fault_detect), .enable_n(enable_n), .status_led(status_led),
		.run_len(run_len), .burst_cnt(burst_cnt), .burst_done(burst_done));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		chk("reads left", 32'h0, rd_q.size());
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk("pready", 32'h1, pready);
		if (pready !== 1'b1) summarize();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		rd_q.push_back({m, exp & m});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_stage(input logic s, input int lim);
		int k = 0;
		while (stage_enable !== s && k < lim) begin
			@(negedge pclk);
			k++;
		end
		chk("stage_enable", s, stage_enable);
		if (stage_enable !== s) summarize();
	endtask : wait_stage

	// The first burst may be cut short, so the count of the next one is noted.
	task automatic blinks(input int code);
		int k = 0;
		while (burst_done !== 1'b1 && k < 600) begin
			@(negedge pclk);
			k++;
		end
		chk("burst end", 32'h1, burst_done);
		if (burst_done !== 1'b1) summarize();
		// Let the end pulse of the cut burst pass so the monitor skips it.
		@(negedge pclk);
		blink_q.push_back(code);
		k = 0;
		while (blink_q.size() > 0 && k < 600) begin
			@(negedge pclk);
			k++;
		end
		chk("burst seen", 32'h0, blink_q.size());
		if (blink_q.size() > 0) summarize();
	endtask : blinks

	task automatic cycle_enable();
		@(posedge pclk);
		disable_req <= 1'b1;
		repeat (3) @(posedge pclk);
		disable_req <= 1'b0;
	endtask : cycle_enable

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
			e = rd_q.pop_front();
			chk("prdata", e[31:0], prdata & e[63:32]);
		end
		if (burst_done && blink_q.size() > 0) begin
			chk("blinks", blink_q.pop_front(), burst_cnt);
		end
	end

	initial begin
		repeat (90000) @(posedge pclk);
		chk("run time", 32'h0, 32'h1);
		summarize();
	end

	initial begin
		seed = 9;
		num_errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fault_req = 19'h0;
		disable_req = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(fault_pkg::ADDR_CTRL, 32'h1, 32'hFFFFFFFF);
		rd(fault_pkg::ADDR_CLASS, 32'h7FF9F, 32'hFFFFFFFF);
		rd(fault_pkg::ADDR_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
		rd(8'h40, 32'h0, 32'hFFFFFFFF);
		repeat (30) @(negedge pclk);
		chk("fast phase", FAST, run_len);
		chk("stage off", 32'h0, stage_enable);
		@(posedge pclk);
		disable_req <= 1'b0;
		wait_stage(1'b1, 10);
		repeat (12) @(negedge pclk);
		chk("led steady", 32'h1, status_led);
		rd(fault_pkg::ADDR_STATUS, 32'h101, 32'h1FF);
		for (int i = 0; i < fault_pkg::NUM_SRC; i++) begin
			@(posedge pclk);
			fault_req <= 19'h1 << i;
			wait_stage(1'b0, 4);
			blinks(i + 2);
			@(posedge pclk);
			fault_req <= 19'h0;
			if (fault_pkg::LATCH_CLASS_RESET[i]) begin
				repeat (30) @(negedge pclk);
				chk("held stage", 32'h0, stage_enable);
				cycle_enable();
				wait_stage(1'b1, 10);
			end else begin
				n = 0;
				while (stage_enable !== 1'b1 && n < 100) begin
					@(negedge pclk);
					n++;
				end
				chk("recover window", 32'h1, n >= RECOVER && n <= RECOVER + 4);
			end
		end
		@(posedge pclk);
		fault_req <= 19'h82;
		blinks(3);
		@(posedge pclk);
		fault_req <= 19'h80;
		cycle_enable();
		blinks(9);
		@(posedge pclk);
		fault_req <= 19'h1;
		wait_stage(1'b0, 4);
		@(posedge pclk);
		fault_req <= 19'h0;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_stage(1'b1, 10);
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			apb(1'b1, fault_pkg::ADDR_IRQ_MASK, v);
			rd(fault_pkg::ADDR_IRQ_MASK, v & 32'h7, 32'hFFFFFFFF);
		end
		apb(1'b1, fault_pkg::ADDR_CTRL, 32'h3);
		apb(1'b1, fault_pkg::ADDR_IRQ_MASK, 32'h4);
		@(posedge pclk);
		fault_req <= 19'h4;
		repeat (4) @(negedge pclk);
		chk("peak", 32'h43, peak_limit_pct);
		chk("stage fold", 32'h1, stage_enable);
		chk("fold flag", 32'h1, foldback_active);
		chk("irq", 32'h1, irq);
		rd(fault_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
		apb(1'b1, fault_pkg::ADDR_IRQ_STAT, 32'h4);
		@(negedge pclk);
		chk("irq clear", 32'h0, irq);
		@(posedge pclk);
		fault_req <= 19'h0;
		repeat (4) @(negedge pclk);
		chk("peak full", 32'h64, peak_limit_pct);
		chk("fold off", 32'h0, foldback_active);
		summarize();
	end
endmodule : tb_top
